// File: inc/srap_consts.vh
// Purpose: constants of the serial register access port
// Assumes: byte-wide register file behind a four-wire serial slave
// Notes:   bit counts count serial clock rising edges inside one frame
`ifndef SRAP_CONSTS_VH
`define SRAP_CONSTS_VH

// ***********************************************************
// frame layout
// ***********************************************************
`define SRAP_CNT_W        5
`define SRAP_BIT_DIR      5'd0
`define SRAP_BIT_ADDR_END 5'd15
`define SRAP_BIT_DATA     5'd16
`define SRAP_BIT_LAST     5'd23
`define SRAP_BIT_DONE     5'd24
`define SRAP_ADDR_W       15
`define SRAP_DATA_W       8

// ***********************************************************
// configuration registers kept inside the port
// ***********************************************************
`define SRAP_ADDR_CFG_A   15'h0000
`define SRAP_RST_CFG_A    8'h30
`define SRAP_POS_ASC      5
`define SRAP_ADDR_USR0    15'h0010
`define SRAP_RST_USR0     8'h00
`define SRAP_POS_HOLD     0

`endif

// File: verilog/srap_regmem.v
// Purpose: byte-wide register storage for the serial port
// Assumes: one write and one read port on the system clock
// Notes:   read data is registered, valid one clock after re_i
`timescale 1ns/1ps
`default_nettype none
module srap_regmem #(
  parameter AW = 8,
  parameter DW = 8
) (
  input  wire          clk_i,
  input  wire          srst_i,
  input  wire          we_i,
  input  wire [AW-1:0] waddr_i,
  input  wire [DW-1:0] wdata_i,
  input  wire          re_i,
  input  wire [AW-1:0] raddr_i,
  output reg  [DW-1:0] rdata_o
);
  reg [DW-1:0] mem_ff [0:(1<<AW)-1];

  // ***********************************************************
  // storage write
  // ***********************************************************
  always @(posedge clk_i) begin
    if (we_i) begin
      mem_ff[waddr_i] <= wdata_i;
    end
  end

  // ***********************************************************
  // registered read
  // ***********************************************************
  always @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= {DW{1'b0}};
    end else if (re_i) begin
      rdata_o <= mem_ff[raddr_i];
    end
  end
endmodule
`default_nettype wire

// File: verilog/srap_top.v
// Purpose: four-wire serial slave giving a host access to the register file
// Assumes: serial pins are asynchronous; serial clock half period >= 4 CLK_I periods
// Notes:   registers above the storage depth read as zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
`include "srap_consts.vh"
module srap_top #(
  parameter MEM_AW = 8
) (
  input  wire CLK_I,
  input  wire SRST_I,
  input  wire SERIAL_SELECT_N_I,
  input  wire SERIAL_CLK_I,
  input  wire SERIAL_IN_I,
  output reg  SERIAL_OUT_O,
  output reg  SERIAL_OUT_OE_N_O
);
  // ***********************************************************
  // helpers
  // ***********************************************************
  // next address of a streaming transfer
  function [`SRAP_ADDR_W-1:0] step_addr;
    input [`SRAP_ADDR_W-1:0] a;
    input                    asc;
    begin
      if (asc) begin
        step_addr = a + 15'h0001;
      end else begin
        step_addr = a - 15'h0001;
      end
    end
  endfunction

  // address lies inside the storage array
  function in_mem;
    input [`SRAP_ADDR_W-1:0] a;
    begin
      in_mem = ((a >> MEM_AW) == {`SRAP_ADDR_W{1'b0}});
    end
  endfunction

  // ***********************************************************
  // pin synchronisers
  // ***********************************************************
  reg sck_s1_ff;
  reg sck_s2_ff;
  reg sck_s3_ff;
  reg sel_s1_ff;
  reg sel_s2_ff;
  reg sdi_s1_ff;
  reg sdi_s2_ff;

  // two flops per pin, a third on the serial clock for edge detection
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      sck_s1_ff <= 1'b0;
      sck_s2_ff <= 1'b0;
      sck_s3_ff <= 1'b0;
      sel_s1_ff <= 1'b1;
      sel_s2_ff <= 1'b1;
      sdi_s1_ff <= 1'b0;
      sdi_s2_ff <= 1'b0;
    end else begin
      sck_s1_ff <= SERIAL_CLK_I;
      sck_s2_ff <= sck_s1_ff;
      sck_s3_ff <= sck_s2_ff;
      sel_s1_ff <= SERIAL_SELECT_N_I;
      sel_s2_ff <= sel_s1_ff;
      sdi_s1_ff <= SERIAL_IN_I;
      sdi_s2_ff <= sdi_s1_ff;
    end
  end

  wire selected = ~sel_s2_ff;
  wire sck_rise = selected & sck_s2_ff & ~sck_s3_ff;
  wire sck_fall = selected & ~sck_s2_ff & sck_s3_ff;

  // ***********************************************************
  // frame state
  // ***********************************************************
  reg [`SRAP_CNT_W-1:0]  cnt_ff;
  reg                    rd_ff;
  reg [`SRAP_ADDR_W-1:0] addr_ff;
  reg [6:0]              din_ff;
  reg [7:0]              dout_ff;
  reg [7:0]              cfg_a_ff;
  reg [7:0]              usr0_ff;

  reg [`SRAP_CNT_W-1:0]  nxt_cnt;
  reg                    nxt_rd;
  reg [`SRAP_ADDR_W-1:0] nxt_addr;
  reg [6:0]              nxt_din;
  reg                    mem_we;
  reg                    mem_re;
  reg [7:0]              wbyte;

  wire asc  = cfg_a_ff[`SRAP_POS_ASC];
  wire hold = usr0_ff[`SRAP_POS_HOLD];

  // bit counting, address capture and byte assembly on rising edges
  always @* begin
    nxt_cnt  = cnt_ff;
    nxt_rd   = rd_ff;
    nxt_addr = addr_ff;
    nxt_din  = din_ff;
    mem_we   = 1'b0;
    mem_re   = 1'b0;
    wbyte    = {din_ff, sdi_s2_ff};
    if (!selected) begin
      nxt_cnt = `SRAP_BIT_DIR;
    end else if (sck_rise && cnt_ff != `SRAP_BIT_DONE) begin
      nxt_cnt = cnt_ff + 5'd1;
      if (cnt_ff == `SRAP_BIT_DIR) begin
        nxt_rd = sdi_s2_ff;
      end else if (cnt_ff <= `SRAP_BIT_ADDR_END) begin
        nxt_addr = {addr_ff[13:0], sdi_s2_ff};
        if (cnt_ff == `SRAP_BIT_ADDR_END) begin
          mem_re = rd_ff;
        end
      end else begin
        nxt_din = {din_ff[5:0], sdi_s2_ff};
        if (cnt_ff == `SRAP_BIT_LAST) begin
          mem_we = ~rd_ff;
          if (hold) begin
            nxt_cnt = `SRAP_BIT_DONE;
          end else begin
            nxt_cnt  = `SRAP_BIT_DATA;
            nxt_addr = step_addr(addr_ff, asc);
            mem_re   = rd_ff;
          end
        end
      end
    end
  end

  always @(posedge CLK_I) begin
    if (SRST_I) begin
      cnt_ff  <= `SRAP_BIT_DIR;
      rd_ff   <= 1'b0;
      addr_ff <= {`SRAP_ADDR_W{1'b0}};
      din_ff  <= 7'h00;
    end else begin
      cnt_ff  <= nxt_cnt;
      rd_ff   <= nxt_rd;
      addr_ff <= nxt_addr;
      din_ff  <= nxt_din;
    end
  end

  // ***********************************************************
  // configuration kept in flops so it steers streaming
  // ***********************************************************
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      cfg_a_ff <= `SRAP_RST_CFG_A;
      usr0_ff  <= `SRAP_RST_USR0;
    end else if (mem_we) begin
      if (addr_ff == `SRAP_ADDR_CFG_A) begin
        cfg_a_ff <= wbyte;
      end
      if (addr_ff == `SRAP_ADDR_USR0) begin
        usr0_ff <= wbyte;
      end
    end
  end

  // ***********************************************************
  // storage and read data selection
  // ***********************************************************
  wire [7:0] mem_rdata;

  srap_regmem #(
    .AW (MEM_AW),
    .DW (`SRAP_DATA_W)
  ) u_mem (
    .clk_i   (CLK_I),
    .srst_i  (SRST_I),
    .we_i    (mem_we & in_mem(addr_ff)),
    .waddr_i (addr_ff[MEM_AW-1:0]),
    .wdata_i (wbyte),
    .re_i    (mem_re),
    .raddr_i (nxt_addr[MEM_AW-1:0]),
    .rdata_o (mem_rdata)
  );

  reg [7:0] rsel;

  // configuration bytes come from their flops, out of range reads as zero
  always @* begin
    if (addr_ff == `SRAP_ADDR_CFG_A) begin
      rsel = cfg_a_ff;
    end else if (addr_ff == `SRAP_ADDR_USR0) begin
      rsel = usr0_ff;
    end else if (in_mem(addr_ff)) begin
      rsel = mem_rdata;
    end else begin
      rsel = 8'h00;
    end
  end

  // ***********************************************************
  // serial output: data changed on falling edges only, enable also released on deselect
  // ***********************************************************
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      SERIAL_OUT_O      <= 1'b0;
      SERIAL_OUT_OE_N_O <= 1'b1;
      dout_ff           <= 8'h00;
    end else if (!selected) begin
      SERIAL_OUT_OE_N_O <= 1'b1;
    end else if (sck_fall) begin
      if (!rd_ff || cnt_ff < `SRAP_BIT_DATA || cnt_ff == `SRAP_BIT_DONE) begin
        SERIAL_OUT_OE_N_O <= 1'b1;
      end else if (cnt_ff == `SRAP_BIT_DATA) begin
        SERIAL_OUT_OE_N_O <= 1'b0;
        SERIAL_OUT_O      <= rsel[7];
        dout_ff           <= {rsel[6:0], 1'b0};
      end else begin
        SERIAL_OUT_O <= dout_ff[7];
        dout_ff      <= {dout_ff[6:0], 1'b0};
      end
    end
  end
endmodule
`default_nettype wire

// File: sim/srap_assertions.sv
// Purpose: port checks for the serial register port
// Assumes: serial pins change just after CLK_I edges
// Notes:   bit count follows serial clock rises
`timescale 1ns/1ps
`default_nettype none
module srap_assertions (
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic SERIAL_SELECT_N_I,
  input wire logic SERIAL_CLK_I,
  input wire logic SERIAL_IN_I,
  input wire logic SERIAL_OUT_O,
  input wire logic SERIAL_OUT_OE_N_O
);
  logic       sck_ff;
  logic       dir_ff;
  logic [7:0] cnt_ff;
  wire logic  rise = SERIAL_CLK_I & ~sck_ff;
  wire logic  oe_n = SERIAL_OUT_OE_N_O;
  wire logic  rd_bit = rise && dir_ff && cnt_ff >= 8'h10 && cnt_ff <= 8'h17;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  // ***************************
  // saturating frame bit count
  // ***************************
  always @(posedge CLK_I) begin
    sck_ff <= SERIAL_CLK_I;
    if (SRST_I || SERIAL_SELECT_N_I) cnt_ff <= 8'h00;
    else if (rise && cnt_ff != 8'hff) cnt_ff <= cnt_ff + 8'h01;
    if (rise && cnt_ff == 8'h00) dir_ff <= SERIAL_IN_I;
  end
  sel_idle_a: assert property (SERIAL_SELECT_N_I [*5] |-> oe_n)
    else $error("driven while idle");
  addr_quiet_a: assert property (cnt_ff != 8'h00 && cnt_ff < 8'h10 |-> oe_n)
    else $error("driven in header");
  write_quiet_a: assert property (cnt_ff != 8'h00 && !dir_ff |-> oe_n)
    else $error("driven in write");
  read_drive_a: assert property (rd_bit |-> !oe_n)
    else $error("data bit undriven");
  read_start_a: assert property ($fell(SERIAL_CLK_I) && dir_ff && cnt_ff == 8'h10
    |-> ##[1:4] !oe_n) else $error("late first bit");
  oe_fall_a: assert property ($fell(oe_n) |-> !SERIAL_CLK_I && dir_ff && cnt_ff >= 8'h10)
    else $error("early drive");
  out_edge_a: assert property (!oe_n && $changed(SERIAL_OUT_O) |-> !SERIAL_CLK_I)
    else $error("bit changed in high phase");
  out_hold_a: assert property (rise && !oe_n |=> $stable(SERIAL_OUT_O) [*3])
    else $error("bit not held");
  cover property (rd_bit && cnt_ff == 8'h17);
  cover property (rise && !dir_ff && cnt_ff == 8'h17);
  cover property (rise && cnt_ff == 8'h1f);
endmodule
bind srap_top srap_assertions i_chk (.CLK_I(CLK_I), .SRST_I(SRST_I),
  .SERIAL_SELECT_N_I(SERIAL_SELECT_N_I), .SERIAL_CLK_I(SERIAL_CLK_I),
  .SERIAL_IN_I(SERIAL_IN_I), .SERIAL_OUT_O(SERIAL_OUT_O), .SERIAL_OUT_OE_N_O(SERIAL_OUT_OE_N_O));
`default_nettype wire

// File: sim/srap_host.sv
// Purpose: serial master model of the host
// Assumes: timing counted in CLK_I periods
// Notes:   serial clock idles low between frames
`timescale 1ns/1ps
`default_nettype none
module srap_host (
  input  wire logic clk_i,
  output logic      sel_n_o,
  output logic      sck_o,
  output logic      sdi_o,
  input  wire logic sdo_i
);
  initial {sel_n_o, sck_o, sdi_o} = 3'b100;
  // wait n edges, then step past the edge
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // select; data line is scrambled outside frames
  task automatic sel(input logic lvl);
    wt(5);
    sel_n_o = lvl;
    sdi_o = ~sdi_o;
    wt(5);
  endtask
  // n bits msb first, hp cycles per phase, sdo taken at each rise
  task automatic bits(input int n, input logic [31:0] v, input int hp, output logic [31:0] r);
    int i;
    r = 32'h0;
    for (i = n - 1; i >= 0; i--) begin
      sdi_o = v[i];
      wt(hp);
      r = {r[30:0], sdo_i};
      sck_o = 1'b1;
      wt(hp);
      sck_o = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// File: sim/test_serial_register_access_port.sv
// Purpose: self-checking bench for the serial register port
// Assumes: the host model drives every serial input pin
// Notes:   a byte model predicts each read byte
`timescale 1ns/1ps
`default_nettype none
module test_serial_register_access_port;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  wire logic   sel_n, sck, serial_in, out, oe_n;
  wire logic   serial_out = oe_n ? 1'bz : out;
  int          seed = 32'h5445;
  int          failures = 0;
  int          total_checks = 0;
  int          i;
  logic [31:0] r;
  logic [7:0]  mem [0:255];
  logic [7:0]  wb [0:255];
  srap_top #(.MEM_AW(8)) i_dut (.CLK_I(clk), .SRST_I(rst), .SERIAL_SELECT_N_I(sel_n),
    .SERIAL_CLK_I(sck), .SERIAL_IN_I(serial_in), .SERIAL_OUT_O(out), .SERIAL_OUT_OE_N_O(oe_n));
  srap_host i_host (.clk_i(clk), .sel_n_o(sel_n), .sck_o(sck), .sdi_o(serial_in), .sdo_i(serial_out));
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch read byte expected %h seen %h", e, g);
    end
  endtask
  // output enable as seen at the end of each data byte
  task automatic chk_oe(input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch output enable expected %b seen %b", e, g);
    end
  endtask
  // expected read byte: storage model, zero above the array
  function automatic logic [7:0] exp_rd(input logic [14:0] x);
    exp_rd = (x < 15'h100) ? mem[x[7:0]] : 8'h00;
  endfunction
  // one frame of n bytes from wb; reads compared, writes kept in mem
  task automatic acc(input logic rd, input logic [14:0] a0, input int n, input int hp);
    logic [14:0] x;
    logic        h;
    int          k;
    h = mem[16][0];
    i_host.sel(1'b0);
    i_host.bits(16, {16'h0, rd, a0}, hp, r);
    for (k = 0; k < n; k++) begin
      x = h ? a0 : 15'(mem[0][5] ? a0 + k : a0 - k);
      i_host.bits(8, {24'h0, wb[k]}, hp, r);
      if (rd) chk((h && k > 0) ? 8'hzz : exp_rd(x), r[7:0]);
      else if (!(h && k > 0) && x < 15'h100) mem[x[7:0]] = wb[k];
      chk_oe(!rd || (h && k > 0), oe_n);
    end
    i_host.sel(1'b1);
  endtask
  task automatic results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (80000) @(posedge clk);
    failures++;
    results();
  end
  initial begin
    mem[0] = 8'h30;
    mem[16] = 8'h00;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    acc(1'b1, 15'h0, 1, 4);
    acc(1'b1, 15'h10, 1, 6);
    for (i = 0; i < 224; i++) wb[i] = 8'($random(seed));
    acc(1'b0, 15'h20, 224, 4);
    for (i = 0; i < 24; i++) begin
      wb[0] = 8'($random(seed));
      acc(i[0], 15'(32 + {$random(seed)} % 224), 1, 4 + i % 7);
    end
    acc(1'b1, 15'hfe, 3, 60);
    wb[0] = 8'h10;
    acc(1'b0, 15'h0, 1, 4);
    acc(1'b0, 15'h90, 3, 5);
    acc(1'b1, 15'h91, 4, 4);
    // mid-run reset: direction bit returns to ascending, storage is kept
    rst = 1'b1;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    mem[0] = 8'h30;
    acc(1'b1, 15'h0, 1, 4);
    acc(1'b1, 15'h8f, 2, 4);
    wb[0] = 8'h30;
    acc(1'b0, 15'h0, 1, 4);
    wb[0] = 8'h01;
    acc(1'b0, 15'h10, 1, 4);
    acc(1'b0, 15'h50, 3, 4);
    acc(1'b1, 15'h4f, 3, 4);
    wb[0] = 8'h00;
    acc(1'b0, 15'h10, 1, 4);
    acc(1'b1, 15'h4f, 3, 4);
    wb[0] = 8'h5a;
    acc(1'b0, 15'h7fff, 1, 4);
    acc(1'b1, 15'h7fff, 1, 4);
    i_host.sel(1'b0);
    i_host.bits(23, {9'h0, 1'b0, 15'h33, 7'h55}, 4, r);
    i_host.sel(1'b1);
    acc(1'b1, 15'h33, 2, 4);
    results();
  end
endmodule
`default_nettype wire
